// ### rvc_config_regs.sv
// Purpose: Rail-2 configuration and status bank with its derived control outputs
// Assumes: Command port already decoded from the management bus, inputs synchronous
// Notes:   One request per cycle, answer on the next enabled edge
`timescale 1ns/1ps
`default_nettype none
`include "rvc_defs.svh"
module rvc_config_regs
	import rvc_pkg::*;
(
	input  wire logic         clock,
	input  wire logic         reset_n,
	input  wire logic         ce,
	input  wire logic         cmd_valid,
	input  wire rvc_cmd_t     cmd,
	output rvc_rsp_t          rsp,
	input  wire logic [1:0]   report_sel,
	input  wire rvc_vid_src_t vid_source,
	input  wire rvc_margin_t  margin_select,
	input  wire logic [8:0]   ext_vid,
	input  wire logic         divider_fitted,
	input  wire logic         vid_res_coarse,
	input  wire logic         diff_half_gain,
	input  wire logic [7:0]   adc_sense,
	input  wire logic         set_raw,
	input  wire logic         slope_switch_off,
	input  wire logic         discontinuous_conduction,
	input  wire logic         input_power_over,
	input  wire logic         input_current_over,
	input  wire logic         enable1,
	input  wire logic         enable2,
	input  wire logic         write_protect_on,
	output logic      [8:0]   ref_vid,
	output logic      [12:0]  ref_mv,
	output logic signed [16:0] trim_uv,
	output logic      [6:0]   transition_slew,
	output logic              slew_is_fast,
	output logic      [7:0]   load_line_mirror_gain,
	output logic              set_gated,
	output logic              pwm_fault,
	output logic              overpower_hiccup,
	output logic              overpower_latched,
	output logic              current_sum_signal_on,
	output logic              on_time_fraction_on,
	output logic              protect_nonvolatile_store,
	output logic              protect_operating,
	output logic              nonvolatile_store_power,
	output logic              telemetry_format_select,
	output logic      [1:0]   input_sense_exponent,
	output logic      [7:0]   input_sense_gain
);
	localparam int NREG = 13;
	localparam logic [7:0] CODES [NREG] = '{
		`RVC_OFS_REF_COMMAND, `RVC_OFS_OUTPUT_TRIM, `RVC_OFS_CAL_OFFSET, `RVC_OFS_UPPER_CLAMP,
		`RVC_OFS_MARGIN_HIGH, `RVC_OFS_MARGIN_LOW, `RVC_OFS_SLEW_RATE, `RVC_OFS_LOAD_LINE,
		`RVC_OFS_SENSE_OPTS, `RVC_OFS_LOWER_CLAMP, `RVC_OFS_PWM_FAULT, `RVC_OFS_MISC_CONFIG,
		`RVC_OFS_INPUT_SCALE};
	localparam logic [15:0] MASKS [NREG] = '{
		`RVC_MASK_VID9, `RVC_MASK_TRIM, `RVC_MASK_BYTE, `RVC_MASK_VID9,
		`RVC_MASK_VID9, `RVC_MASK_VID9, `RVC_MASK_SLEW, `RVC_MASK_BYTE,
		`RVC_MASK_SENSE, `RVC_MASK_VID9, `RVC_MASK_PWM_FAULT, `RVC_MASK_BYTE,
		`RVC_MASK_INPUT_SCALE};
	localparam int I_CMD = 0, I_TRIM = 1, I_CAL = 2, I_MAX = 3, I_MH = 4, I_ML = 5, I_SLEW = 6;
	localparam int I_LL = 7, I_SENSE = 8, I_MIN = 9, I_PWM = 10, I_MISC = 11, I_SCALE = 12;

	// Decodes a command code to a stored-register slot, used by writes and reads
	function automatic logic [4:0] rvc_slot(input logic [7:0] code);
		logic [4:0] slot;
		slot = 5'h1f;
		for (int k = 0; k < NREG; k++)
			if (code == CODES[k])
				slot = 5'(k);
		return slot;
	endfunction

	// Report byte from the selector
	function automatic logic [7:0] rvc_report(input logic [1:0] sel);
		logic [7:0] code;
		code = `RVC_REPORT_VID;
		if (sel[1])
			code = `RVC_REPORT_DIRECT;
		else if (sel[0])
			code = `RVC_REPORT_LINEAR;
		return code;
	endfunction

	logic [1:0]    rst_pipe;
	logic          rst_n;
	logic [15:0]   cfg [NREG];
	logic [4:0]    slot;
	logic          write_ok;
	logic [15:0]   next_rdata;
	logic          next_err;
	logic [8:0]    next_ref_vid;
	logic [7:0]    hiccup_cnt;
	logic          op_trip;
	rvc_op_state_t op_state;
	logic [15:0]   misc;
	logic [15:0]   sense;
	logic [15:0]   pwm_win;

	// Reset release through two flops; assertion is immediate
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			rst_pipe <= 2'b00;
		else
			rst_pipe <= {rst_pipe[0], 1'b1};
	end
	assign rst_n = rst_pipe[1];

	assign slot     = rvc_slot(cmd.code);
	assign misc     = cfg[I_MISC];
	assign sense    = cfg[I_SENSE];
	assign pwm_win  = cfg[I_PWM];
	// Operating-memory protection blocks every write to this bank
	assign write_ok = cmd_valid && cmd.write && slot != 5'h1f && !protect_operating;

	// One storage word per register, writable bits only
	for (genvar g = 0; g < NREG; g++) begin : g_reg
		always_ff @(posedge clock or negedge rst_n) begin
			if (!rst_n)
				cfg[g] <= `RVC_RST_VALUE;
			else if (ce && write_ok && slot == 5'(g))
				cfg[g] <= cmd.wdata & MASKS[g];
		end
	end

	// Read data: stored words are already masked, report byte is computed
	always_comb begin
		next_rdata = 16'h0000;
		next_err   = 1'b0;
		if (cmd.code == `RVC_OFS_REPORT_MODE) begin
			next_rdata = {8'h00, rvc_report(report_sel)};
			next_err   = cmd.write;
		end else if (slot != 5'h1f) begin
			next_rdata = cmd.write ? 16'h0000 : cfg[slot[3:0]];
			next_err   = cmd.write && protect_operating;
		end else
			next_err = 1'b1;
	end

	// Answer one cycle after each request
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			rsp <= '0;
		else if (ce) begin
			rsp.valid <= cmd_valid;
			rsp.err   <= cmd_valid && next_err;
			rsp.data  <= cmd_valid ? next_rdata : 16'h0000;
		end
	end

	rvc_ref_path u_ref_path (
		.mode           (vid_source),
		.margin         (margin_select),
		.cmd_vid        (cfg[I_CMD][8:0]),
		.ext_vid        (ext_vid),
		.margin_high    (cfg[I_MH][8:0]),
		.margin_low     (cfg[I_ML][8:0]),
		.vid_max        (cfg[I_MAX][8:0]),
		.vid_min        (cfg[I_MIN][8:0]),
		.divide_ratio   (sense[8:0]),
		.divider_fitted (divider_fitted),
		.cal_offset     (cfg[I_CAL][7:0]),
		.ref_vid        (next_ref_vid)
	);

	// Reference and its voltage at the selected step size
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ref_vid <= 9'h000;
			ref_mv  <= 13'h0000;
		end else if (ce) begin
			ref_vid <= next_ref_vid;
			ref_mv  <= 13'({4'h0, next_ref_vid} * (vid_res_coarse ? `RVC_STEP_COARSE_MV : `RVC_STEP_FINE_MV));
		end
	end

	// Trim weight follows the differential sense gain
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			trim_uv <= 17'sd0;
		else if (ce)
			trim_uv <= 17'($signed(cfg[I_TRIM][6:0]) *
				(diff_half_gain ? `RVC_TRIM_HALF_UV : `RVC_TRIM_UNITY_UV));
	end

	// Slew means fast slew on the processor bus, transition slew elsewhere
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			transition_slew       <= 7'h00;
			slew_is_fast          <= 1'b0;
			load_line_mirror_gain <= 8'h00;
			input_sense_exponent  <= 2'h0;
			input_sense_gain      <= 8'h00;
		end else if (ce) begin
			transition_slew       <= cfg[I_SLEW][6:0];
			slew_is_fast          <= (vid_source == RVC_SRC_PROC);
			load_line_mirror_gain <= cfg[I_LL][7:0];
			input_sense_exponent  <= cfg[I_SCALE][`RVC_SCALE_EXP_MSB:`RVC_SCALE_EXP_LSB];
			input_sense_gain      <= cfg[I_SCALE][7:0];
		end
	end

	rvc_set_gate u_set_gate (
		.clock                    (clock),
		.rst_n                    (rst_n),
		.ce                       (ce),
		.set_raw                  (set_raw),
		.depth_once               (sense[`RVC_SYNC_DEPTH_BIT]),
		.blank_time               (sense[`RVC_BLANK_MSB:`RVC_BLANK_LSB]),
		.slope_switch_off         (slope_switch_off),
		.discontinuous_conduction (discontinuous_conduction),
		.set_out                  (set_gated)
	);

	// Window compare; thresholds share the sense weight of 100 mV per count
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			pwm_fault <= 1'b0;
		else if (ce)
			pwm_fault <= (adc_sense < {3'b000, pwm_win[`RVC_FAULT_LOW_MSB:`RVC_FAULT_LOW_LSB]}) ||
				(adc_sense > {3'b000, pwm_win[`RVC_FAULT_HIGH_MSB:`RVC_FAULT_HIGH_LSB]});
	end

	// Trigger source chosen by the trigger bit, gated by the guard enable
	assign op_trip = misc[`RVC_OP_GUARD_BIT] &&
		(misc[`RVC_OP_TRIGGER_BIT] ? input_current_over : input_power_over);

	// Overpower response: hiccup retries after a pause, latch-off holds until guard off or reset
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			op_state   <= RVC_OP_IDLE;
			hiccup_cnt <= 8'h00;
		end else if (ce) begin
			case (op_state)
				RVC_OP_IDLE: begin
					if (op_trip && misc[`RVC_OP_RESPONSE_BIT])
						op_state <= RVC_OP_LATCHED;
					else if (op_trip) begin
						op_state   <= RVC_OP_HICCUP;
						hiccup_cnt <= `RVC_HICCUP_CYC;
					end
				end
				RVC_OP_HICCUP: begin
					if (!misc[`RVC_OP_GUARD_BIT] || hiccup_cnt == 8'h01)
						op_state <= RVC_OP_IDLE;
					hiccup_cnt <= hiccup_cnt - 8'h01;
				end
				RVC_OP_LATCHED: begin
					if (!misc[`RVC_OP_GUARD_BIT])
						op_state <= RVC_OP_IDLE;
				end
				default: op_state <= RVC_OP_IDLE;
			endcase
		end
	end

	// Protection flags follow the state
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			overpower_hiccup  <= 1'b0;
			overpower_latched <= 1'b0;
		end else if (ce) begin
			overpower_hiccup  <= (op_state == RVC_OP_HICCUP);
			overpower_latched <= (op_state == RVC_OP_LATCHED);
		end
	end

	// Idle-time and protection controls; with both enables low the store may sleep
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			current_sum_signal_on     <= 1'b0;
			on_time_fraction_on       <= 1'b0;
			protect_nonvolatile_store <= 1'b0;
			protect_operating         <= 1'b0;
			nonvolatile_store_power   <= 1'b1;
			telemetry_format_select   <= 1'b0;
		end else if (ce) begin
			current_sum_signal_on     <= enable1 || enable2 || misc[`RVC_CSUM_KEEP_BIT];
			on_time_fraction_on       <= misc[`RVC_TON_FRAC_BIT];
			protect_nonvolatile_store <= write_protect_on && !misc[`RVC_WP_MODE_BIT];
			protect_operating         <= write_protect_on && misc[`RVC_WP_MODE_BIT];
			nonvolatile_store_power   <= !(misc[`RVC_SLEEP_BIT] && !enable1 && !enable2);
			telemetry_format_select   <= misc[`RVC_TELEM_BIT];
		end
	end

	a_report_byte: assert property (@(posedge clock) disable iff (!rst_n)
		(ce && cmd_valid && !cmd.write && cmd.code == `RVC_OFS_REPORT_MODE) |=>
		(rsp.valid && rsp.data == {8'h00, ($past(report_sel[1]) ? 8'h40 : $past(report_sel[0]) ? 8'h18 : 8'h21)}))
		else $error("report byte wrong");

	a_reserved_zero: assert property (@(posedge clock) disable iff (!rst_n)
		(ce && cmd_valid && !cmd.write && slot != 5'h1f) |=>
		((rsp.data & ~$past(MASKS[slot[3:0]])) == 16'h0000))
		else $error("reserved bits read nonzero");

	a_clamp_upper: assert property (@(posedge clock) disable iff (!rst_n)
		(ce && vid_source != RVC_SRC_PROC && !divider_fitted && cfg[I_CAL][7:0] == 8'h00 &&
		cfg[I_MIN][8:0] <= cfg[I_MAX][8:0]) |=> (ref_vid <= $past(cfg[I_MAX][8:0])))
		else $error("reference above maximum");

	a_clamp_lower: assert property (@(posedge clock) disable iff (!rst_n)
		(ce && vid_source != RVC_SRC_PROC && !divider_fitted && cfg[I_CAL][7:0] == 8'h00) |=>
		(ref_vid >= $past(cfg[I_MIN][8:0])))
		else $error("reference below minimum");

	a_margin_high: assert property (@(posedge clock) disable iff (!rst_n)
		(ce && margin_select == RVC_MARGIN_HIGH && vid_source == RVC_SRC_PROC && cfg[I_CAL][7:0] == 8'h00)
		|=> (ref_vid == $past(cfg[I_MH][8:0])))
		else $error("margin-high not used");

	a_fault_window: assert property (@(posedge clock) disable iff (!rst_n)
		ce |=> (pwm_fault == ($past(adc_sense) < 8'($past(pwm_win[9:5])) ||
		$past(adc_sense) > 8'($past(pwm_win[4:0])))))
		else $error("pwm fault mismatch");

	a_guard_off: assert property (@(posedge clock) disable iff (!rst_n)
		(ce && !misc[`RVC_OP_GUARD_BIT]) ##1 ce |=> !overpower_latched && !overpower_hiccup)
		else $error("overpower active with guard off");

	a_write_block: assert property (@(posedge clock) disable iff (!rst_n)
		(ce && protect_operating && cmd_valid && cmd.write && slot == 5'(I_CMD)) |=>
		$stable(cfg[I_CMD]))
		else $error("write passed protection");

	a_sum_keep: assert property (@(posedge clock) disable iff (!rst_n)
		(ce && !enable1 && !enable2 && !misc[`RVC_CSUM_KEEP_BIT]) |=> !current_sum_signal_on)
		else $error("current sum not disabled");
endmodule // rvc_config_regs
`default_nettype wire

// ### rvc_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts for the rail-2 configuration bank
// Assumes: 100 MHz clock
// Notes:   Definitions only
`ifndef RVC_DEFS_SVH
`define RVC_DEFS_SVH

// Command codes
`define RVC_OFS_REPORT_MODE   8'h20
`define RVC_OFS_REF_COMMAND   8'h21
`define RVC_OFS_OUTPUT_TRIM   8'h22
`define RVC_OFS_CAL_OFFSET    8'h23
`define RVC_OFS_UPPER_CLAMP   8'h24
`define RVC_OFS_MARGIN_HIGH   8'h25
`define RVC_OFS_MARGIN_LOW    8'h26
`define RVC_OFS_SLEW_RATE     8'h27
`define RVC_OFS_LOAD_LINE     8'h28
`define RVC_OFS_SENSE_OPTS    8'h29
`define RVC_OFS_LOWER_CLAMP   8'h2b
`define RVC_OFS_PWM_FAULT     8'h2c
`define RVC_OFS_MISC_CONFIG   8'h35
`define RVC_OFS_INPUT_SCALE   8'h36

// Writable masks, reserved bits are zero here
`define RVC_MASK_VID9         16'h01ff
`define RVC_MASK_TRIM         16'h007f
`define RVC_MASK_BYTE         16'h00ff
`define RVC_MASK_SLEW         16'h007f
`define RVC_MASK_SENSE        16'h3fff
`define RVC_MASK_PWM_FAULT    16'h03ff
`define RVC_MASK_INPUT_SCALE  16'h03ff

// Reset value of every stored register
`define RVC_RST_VALUE         16'h0000

// Report-mode codes
`define RVC_REPORT_DIRECT     8'h40
`define RVC_REPORT_LINEAR     8'h18
`define RVC_REPORT_VID        8'h21

// Field positions
`define RVC_SYNC_DEPTH_BIT    13
`define RVC_BLANK_MSB         12
`define RVC_BLANK_LSB         9
`define RVC_FAULT_LOW_MSB     9
`define RVC_FAULT_LOW_LSB     5
`define RVC_FAULT_HIGH_MSB    4
`define RVC_FAULT_HIGH_LSB    0
`define RVC_OP_TRIGGER_BIT    7
`define RVC_OP_RESPONSE_BIT   6
`define RVC_OP_GUARD_BIT      5
`define RVC_CSUM_KEEP_BIT     4
`define RVC_TON_FRAC_BIT      3
`define RVC_WP_MODE_BIT       2
`define RVC_SLEEP_BIT         1
`define RVC_TELEM_BIT         0
`define RVC_SCALE_EXP_MSB     9
`define RVC_SCALE_EXP_LSB     8

// Weights and timing
`define RVC_TRIM_UNITY_UV     17'sd500
`define RVC_TRIM_HALF_UV      17'sd800
`define RVC_STEP_FINE_MV      4'd5
`define RVC_STEP_COARSE_MV    4'd10
`define RVC_CLK_PERIOD_NS     10
`define RVC_BLANK_LSB_NS      10
`define RVC_BLANK_CYC_PER_LSB ((`RVC_BLANK_LSB_NS + `RVC_CLK_PERIOD_NS - 1) / `RVC_CLK_PERIOD_NS)
`define RVC_HICCUP_CYC        8'd16

`endif

// ### rvc_pkg.sv
// Purpose: Types shared by the rail-2 configuration bank
// Assumes: Nothing
// Notes:   Constants live in rvc_defs.svh
package rvc_pkg;
	typedef struct packed {
		logic        write;
		logic [7:0]  code;
		logic [15:0] wdata;
	} rvc_cmd_t;

	typedef struct packed {
		logic        valid;
		logic        err;
		logic [15:0] data;
	} rvc_rsp_t;

	typedef enum logic [3:0] {
		RVC_SRC_BUS  = 4'h1,
		RVC_SRC_PAR  = 4'h2,
		RVC_SRC_AVS  = 4'h4,
		RVC_SRC_PROC = 4'h8
	} rvc_vid_src_t;

	typedef enum logic [1:0] {
		RVC_MARGIN_NONE = 2'h0,
		RVC_MARGIN_HIGH = 2'h1,
		RVC_MARGIN_LOW  = 2'h2
	} rvc_margin_t;

	typedef enum logic [2:0] {
		RVC_OP_IDLE    = 3'h1,
		RVC_OP_HICCUP  = 3'h2,
		RVC_OP_LATCHED = 3'h4
	} rvc_op_state_t;
endpackage

// ### rvc_ref_path.sv
// Purpose: Selects, clamps and offsets the rail-2 reference voltage ID
// Assumes: Purely combinational, registered by the caller
// Notes:   Clamp applies before the calibration offset
`timescale 1ns/1ps
`default_nettype none
module rvc_ref_path import rvc_pkg::*; (
	input  wire rvc_vid_src_t mode,
	input  wire rvc_margin_t  margin,
	input  wire logic [8:0]   cmd_vid,
	input  wire logic [8:0]   ext_vid,
	input  wire logic [8:0]   margin_high,
	input  wire logic [8:0]   margin_low,
	input  wire logic [8:0]   vid_max,
	input  wire logic [8:0]   vid_min,
	input  wire logic [8:0]   divide_ratio,
	input  wire logic         divider_fitted,
	input  wire logic [7:0]   cal_offset,
	output logic      [8:0]   ref_vid
);
	logic        [8:0]  lim_hi;
	logic        [8:0]  lim_lo;
	logic        [8:0]  request;
	logic        [8:0]  clamped;
	logic signed [10:0] sum;

	// A zero ratio would divide by zero, so it counts as no divider
	always_comb begin
		lim_hi = vid_max;
		lim_lo = vid_min;
		if (divider_fitted && divide_ratio != 9'h000) begin
			lim_hi = vid_max / divide_ratio;
			lim_lo = vid_min / divide_ratio;
		end
	end

	// Margin levels override the interface request
	always_comb begin
		case (margin)
			RVC_MARGIN_HIGH: request = margin_high;
			RVC_MARGIN_LOW:  request = margin_low;
			default:         request = (mode == RVC_SRC_BUS) ? cmd_vid : ext_vid;
		endcase
	end

	// Clamp only outside processor-bus mode, then add the signed offset and saturate
	always_comb begin
		clamped = request;
		if (mode != RVC_SRC_PROC) begin
			if (request > lim_hi)
				clamped = lim_hi;
			else if (request < lim_lo)
				clamped = lim_lo;
		end
		sum = $signed({2'b00, clamped}) + $signed({{3{cal_offset[7]}}, cal_offset});
		if (sum < 11'sd0)
			ref_vid = 9'h000;
		else if (sum > 11'sd511)
			ref_vid = 9'h1ff;
		else
			ref_vid = sum[8:0];
	end
endmodule // rvc_ref_path
`default_nettype wire

// ### rvc_set_gate.sv
// Purpose: Delays the set signal one or two stages and blanks it after slope-switch turn-off
// Assumes: Inputs synchronous to clock
// Notes:   Blanking runs only in discontinuous conduction
`timescale 1ns/1ps
`default_nettype none
`include "rvc_defs.svh"
module rvc_set_gate
(
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic       ce,
	input  wire logic       set_raw,
	input  wire logic       depth_once,
	input  wire logic [3:0] blank_time,
	input  wire logic       slope_switch_off,
	input  wire logic       discontinuous_conduction,
	output logic            set_out
);
	localparam int unsigned CYC_PER_LSB = `RVC_BLANK_CYC_PER_LSB;

	logic       stage1;
	logic       stage2;
	logic [7:0] blank_cnt;

	// Two-stage delay line, stage choice by depth bit
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
		end else if (ce) begin
			stage1 <= set_raw;
			stage2 <= stage1;
		end
	end

	// Blanking counter reloaded while turn-off is high in discontinuous conduction
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			blank_cnt <= 8'h00;
		else if (ce) begin
			if (slope_switch_off && discontinuous_conduction)
				blank_cnt <= 8'(blank_time * CYC_PER_LSB);
			else if (blank_cnt != 8'h00)
				blank_cnt <= blank_cnt - 8'h01;
		end
	end

	// Output gated by blanking
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			set_out <= 1'b0;
		else if (ce)
			set_out <= (depth_once ? stage1 : stage2) && (blank_cnt == 8'h00);
	end

	a_blank_quiet: assert property (@(posedge clock) disable iff (!rst_n)
		(ce && blank_cnt != 8'h00) |=> !set_out)
		else $error("set passed during blanking");

	a_depth_once: assert property (@(posedge clock) disable iff (!rst_n)
		(ce && depth_once && blank_cnt == 8'h00 && $past(ce)) |=> (set_out == $past(set_raw, 2)))
		else $error("single-stage set delay wrong");
endmodule // rvc_set_gate
`default_nettype wire

// ### rvc_host_model.sv
// Purpose: Host-side request driver for the rail-2 configuration bank
// Assumes: ce held high, one request outstanding at a time
// Notes:   Waits a bounded time for the registered answer
`timescale 1ns/1ps
`default_nettype none
module rvc_host_model import rvc_pkg::*; (
	input  wire logic     clock,
	output logic          cmd_valid,
	output rvc_cmd_t      cmd,
	input  wire rvc_rsp_t rsp
);
	// Idle bus at time zero
	initial begin
		cmd_valid = 1'b0;
		cmd = '0;
	end

	// Request held through the taking edge; released fields change so stale data is never trusted
	task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wd, output rvc_rsp_t r);
		r = 'x;
		@(posedge clock);
		cmd_valid <= 1'b1;
		cmd <= '{write: wr, code: code, wdata: wd};
		@(posedge clock);
		cmd_valid <= 1'b0;
		cmd <= '{write: 1'b0, code: ~code, wdata: ~wd};
		// Answer is taken at the edge after the taking edge, before it is replaced
		for (int i = 0; i < 3 && r.valid !== 1'b1; i++) begin
			@(posedge clock);
			if (rsp.valid === 1'b1)
				r = rsp;
		end
	endtask
endmodule // rvc_host_model
`default_nettype wire

// ### rvc_config_regs_tb.sv
// Purpose: Self-checking bench for the rail-2 configuration bank
// Assumes: 100 MHz clock, ce held high
// Notes:   Readback table first, then clamp, fault, protection and reset cases
`timescale 1ns/1ps
`default_nettype none
module rvc_config_regs_tb import rvc_pkg::*; ;
	typedef struct packed {logic [7:0] code; logic [15:0] wd; logic [15:0] rd;} rvc_row_t;
	localparam rvc_row_t ROWS [13] = '{'{8'h21, 16'hffff, 16'h01ff}, '{8'h22, 16'hffff, 16'h007f},
		'{8'h23, 16'hffff, 16'h00ff}, '{8'h24, 16'hffff, 16'h01ff}, '{8'h25, 16'hffff, 16'h01ff},
		'{8'h26, 16'hffff, 16'h01ff}, '{8'h27, 16'hffff, 16'h007f}, '{8'h28, 16'hffff, 16'h00ff},
		'{8'h29, 16'hffff, 16'h3fff}, '{8'h2b, 16'hffff, 16'h01ff}, '{8'h2c, 16'hffff, 16'h03ff},
		'{8'h35, 16'hfffb, 16'h00fb}, '{8'h36, 16'hffff, 16'h03ff}};
	localparam logic [7:0] ADCV [3] = '{8'h01, 8'h03, 8'h06};
	logic clock, reset_n, ce, cmd_valid, divider_fitted, vid_res_coarse, diff_half_gain, set_raw;
	logic slope_switch_off, discontinuous_conduction, input_power_over, input_current_over;
	logic enable1, enable2, write_protect_on, pwm_fault, overpower_hiccup, current_sum_signal_on;
	logic on_time_fraction_on, protect_operating, nonvolatile_store_power, telemetry_format_select;
	logic [1:0] report_sel, input_sense_exponent;
	logic [6:0] transition_slew;
	logic [7:0] adc_sense, input_sense_gain, load_line_mirror_gain;
	logic [12:0] ref_mv;
	logic signed [16:0] trim_uv;
	logic slew_is_fast, set_gated, overpower_latched, protect_nonvolatile_store;
	logic [8:0] ext_vid, ref_vid;
	rvc_vid_src_t vid_source;
	rvc_margin_t margin_select;
	rvc_cmd_t cmd;
	rvc_rsp_t rsp, r;
	int n_errors = 0, n_tests = 0, cycles = 0;

	rvc_host_model host_u (.clock, .cmd_valid, .cmd, .rsp);
	rvc_config_regs dut_u (.clock, .reset_n, .ce, .cmd_valid, .cmd, .rsp, .report_sel, .vid_source,
		.margin_select, .ext_vid, .divider_fitted, .vid_res_coarse, .diff_half_gain, .adc_sense, .set_raw,
		.slope_switch_off, .discontinuous_conduction, .input_power_over, .input_current_over, .enable1,
		.enable2, .write_protect_on, .ref_vid, .ref_mv, .trim_uv, .transition_slew, .slew_is_fast,
		.load_line_mirror_gain, .set_gated, .pwm_fault, .overpower_hiccup, .overpower_latched,
		.current_sum_signal_on, .on_time_fraction_on, .protect_nonvolatile_store, .protect_operating,
		.nonvolatile_store_power, .telemetry_format_select, .input_sense_exponent, .input_sense_gain);

	always #5 clock = ~clock;

	// Hang guard: whole run needs well under a thousand cycles
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_errors++;
			tally_and_finish();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic acc(input logic wr, input logic [7:0] code, input logic [15:0] wd);
		host_u.xfer(wr, code, wd, r);
	endtask

	// Derived outputs lag a write by two cycles; four leaves margin
	task automatic settle;
		repeat (4) @(posedge clock);
		#1;
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		{clock, reset_n, divider_fitted, vid_res_coarse, diff_half_gain, set_raw, slope_switch_off} = '0;
		{discontinuous_conduction, input_power_over, input_current_over, enable1, enable2} = '0;
		{write_protect_on, report_sel, adc_sense, ext_vid} = '0;
		ce = 1'b1;
		vid_source = RVC_SRC_BUS;
		margin_select = RVC_MARGIN_NONE;
		repeat (10) @(posedge clock);
		reset_n <= 1'b1;
		repeat (5) @(posedge clock);
		// Readback table: reserved bits drop out
		foreach (ROWS[i]) begin
			acc(1'b1, ROWS[i].code, ROWS[i].wd);
			check(r.err, 1'b0);
			acc(1'b0, ROWS[i].code, 16'h0000);
			check(r.data, ROWS[i].rd);
		end
		settle();
		check(transition_slew, 7'h7f);
		check({input_sense_exponent, input_sense_gain}, 10'h3ff);
		check({current_sum_signal_on, on_time_fraction_on}, 2'b11);
		check({nonvolatile_store_power, telemetry_format_select}, 2'b01);
		check(load_line_mirror_gain, 8'hff);
		check(trim_uv, -32'sd500);
		// Single-stage delay: set shows two edges after the input rises
		@(posedge clock) set_raw <= 1'b1;
		repeat (2) @(posedge clock);
		#1;
		check(set_gated, 1'b1);
		// Blanking field 15 holds set low for 15 cycles after a turn-off in discontinuous mode
		@(posedge clock) {slope_switch_off, discontinuous_conduction} <= 2'b11;
		@(posedge clock) slope_switch_off <= 1'b0;
		settle();
		check(set_gated, 1'b0);
		repeat (4) settle();
		check(set_gated, 1'b1);
		for (int s = 0; s < 4; s++) begin
			@(posedge clock) report_sel <= 2'(s);
			acc(1'b0, 8'h20, 16'h0000);
			check(r.data, (s >= 2) ? 32'h40 : (s == 1) ? 32'h18 : 32'h21);
		end
		acc(1'b1, 8'h20, 16'h00ff);
		check(r.err, 1'b1);
		acc(1'b0, 8'h30, 16'h0000);
		check({r.err, r.data}, 17'h10000);
		// Clamp window 0x020..0x100, no offset
		acc(1'b1, 8'h24, 16'h0100);
		acc(1'b1, 8'h2b, 16'h0020);
		acc(1'b1, 8'h23, 16'h0000);
		acc(1'b1, 8'h21, 16'h01ff);
		settle();
		check(ref_vid, 9'h100);
		check(ref_mv, 13'd1280);
		@(posedge clock) vid_source <= RVC_SRC_PAR;
		ext_vid <= 9'h005;
		settle();
		check(ref_vid, 9'h020);
		// Ratio 2 halves the window to 0x010..0x080
		acc(1'b1, 8'h29, 16'h0002);
		divider_fitted <= 1'b1;
		settle();
		check(ref_vid, 9'h010);
		acc(1'b1, 8'h25, 16'h0080);
		margin_select <= RVC_MARGIN_HIGH;
		vid_source <= RVC_SRC_PROC;
		divider_fitted <= 1'b0;
		vid_res_coarse <= 1'b1;
		settle();
		check(ref_vid, 9'h080);
		check(slew_is_fast, 1'b1);
		check(ref_mv, 13'd1280);
		acc(1'b1, 8'h26, 16'h0040);
		margin_select <= RVC_MARGIN_LOW;
		vid_source <= RVC_SRC_PAR;
		settle();
		check(ref_vid, 9'h040);
		@(posedge clock) margin_select <= RVC_MARGIN_NONE;
		ext_vid <= 9'h050;
		acc(1'b1, 8'h23, 16'h00ff);
		settle();
		check(ref_vid, 9'h04f);
		// Fault window: low 2, high 5
		acc(1'b1, 8'h2c, 16'h0045);
		for (int k = 0; k < 3; k++) begin
			@(posedge clock) adc_sense <= ADCV[k];
			settle();
			check(pwm_fault, k != 1);
		end
		acc(1'b1, 8'h35, 16'h0020);
		input_power_over <= 1'b1;
		enable1 <= 1'b1;
		settle();
		check(overpower_hiccup, 1'b1);
		check(current_sum_signal_on, 1'b1);
		// Latch-off response: the next trip after the hiccup pause latches
		acc(1'b1, 8'h35, 16'h0060);
		repeat (5) settle();
		check(overpower_latched, 1'b1);
		@(posedge clock) input_power_over <= 1'b0;
		acc(1'b1, 8'h35, 16'h0004);
		write_protect_on <= 1'b1;
		diff_half_gain <= 1'b1;
		settle();
		check({protect_operating, protect_nonvolatile_store}, 2'b10);
		check(trim_uv, -32'sd800);
		acc(1'b1, 8'h21, 16'h0011);
		check(r.err, 1'b1);
		acc(1'b0, 8'h21, 16'h0000);
		check(r.data, 16'h01ff);
		// Second reset mid-run
		@(posedge clock) reset_n <= 1'b0;
		write_protect_on <= 1'b0;
		settle();
		check({nonvolatile_store_power, ref_vid}, 10'h200);
		@(posedge clock) reset_n <= 1'b1;
		repeat (5) @(posedge clock);
		acc(1'b0, 8'h21, 16'h0000);
		check(r.data, 16'h0000);
		tally_and_finish();
	end
endmodule // rvc_config_regs_tb
`default_nettype wire
